// file: include/smf_pkg.sv
// shared constants and carriers for the serial measurement packet framer
package smf_pkg;
    // register byte offsets
    localparam logic [7:0] SMF_A_CTRL   = 8'h00; // enable, change request
    localparam logic [7:0] SMF_A_WIDTH  = 8'h04; // value widths per type
    localparam logic [7:0] SMF_A_STATUS = 8'h08; // sticky events
    localparam logic [7:0] SMF_A_MASK   = 8'h0C; // interrupt mask
    localparam logic [7:0] SMF_A_STATE  = 8'h10; // live framer state
    // field positions
    localparam int SMF_CTRL_EN_BIT  = 0;  // framer enable
    localparam int SMF_CTRL_CFG_BIT = 1;  // write 1: flag a config change
    localparam int SMF_WID_MEAS_LSB = 0;  // measurement width field
    localparam int SMF_WID_VID_LSB  = 8;  // video width field
    localparam int SMF_EV_FRAME     = 0;  // frame closed
    localparam int SMF_EV_LOST      = 1;  // frame dropped
    localparam int SMF_EV_DUP       = 2;  // second measurement packet
    localparam int SMF_EV_N         = 3;  // number of event bits
    // reset values
    localparam logic       SMF_RST_EN   = 1'h1;
    localparam logic [5:0] SMF_RST_WMEAS = 6'h20; // 32 bit
    localparam logic [5:0] SMF_RST_WVID  = 6'h0E; // 14 bit
    localparam logic [SMF_EV_N-1:0] SMF_RST_MASK = 3'h0;
    // value geometry
    localparam logic [5:0] SMF_W_MIN = 6'h0E; // narrowest value
    localparam logic [5:0] SMF_W_MAX = 6'h20; // widest value
    localparam int         SMF_GRP   = 7;     // payload bits per byte
    // payload type codes
    localparam logic [1:0] SMF_PT_MEAS  = 2'h0;
    localparam logic [1:0] SMF_PT_VIDEO = 2'h1;

    // one value offered by the measuring core
    typedef struct packed {
        logic [31:0] data;  // raw value, lsb aligned
        logic        video; // belongs to a video packet
        logic        last;  // last value of its packet
        logic        eof;   // its packet closes the frame
    } smf_val_t;

    // closing byte of a packet
    typedef struct packed {
        logic       cont;  // always 0
        logic       ext;   // another footer byte follows
        logic       sep;   // always 0, keeps it apart from '>'
        logic       eof;   // last packet of the frame
        logic       cfg;   // configuration changed
        logic [1:0] ptype; // payload_type
        logic       ovf;   // frames were lost
    } smf_footer_t;

    typedef enum logic [2:0] {
        SMF_ST_IDLE = 3'b000, // between frames
        SMF_ST_ASC  = 3'b001, // one reply byte waiting
        SMF_ST_TAKE = 3'b010, // waiting for a value
        SMF_ST_SEND = 3'b011, // emitting value bytes
        SMF_ST_FOOT = 3'b100  // emitting the footer
    } smf_state_t;

    // keeps only the low w bits
    function automatic logic [31:0] smf_mask(input logic [5:0] w);
        smf_mask = (w >= SMF_W_MAX) ? 32'hFFFF_FFFF
                                     : ((32'h0000_0001 << w) - 32'h0000_0001);
    endfunction
endpackage

// file: src/smf_val_enc.sv
`timescale 1ns/1ps
// trims a value to its width and works out how many bytes carry it
module smf_val_enc
    import smf_pkg::*;
#(
    parameter int DW = 32                  // value width
) (
    input  wire logic [DW-1:0] i_data,     // raw value
    input  wire logic [5:0]    i_width,    // width in use, 14..32
    output logic      [DW-1:0] o_data,     // value, unused bits zero
    output logic      [2:0]    o_nbytes    // bytes on the line, 2..5
);
    // the byte layout only has room for 32 bits
    if (DW != 32) begin : g_chk
        $error("smf_val_enc: DW must be 32");
    end

    // clearing unused bits here zero-fills the top byte for widths up to 28; five-byte values get their top bits from the shift
    always_comb begin
        o_data = i_data & smf_mask(i_width);
        if (i_width <= 6'h0E) begin
            o_nbytes = 3'h2;
        end else if (i_width <= 6'h15) begin
            o_nbytes = 3'h3;
        end else if (i_width <= 6'h1C) begin
            o_nbytes = 3'h4;
        end else begin
            o_nbytes = 3'h5;
        end
    end
endmodule

// file: src/smf_framer.sv
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - bit 7 set while value bytes follow
// - lsb first, 7-bit groups, two to five bytes
// - widths 14 to 32, unused bits zero
// - widths only change at frame boundaries
// - footer layout: 0,ext,0,eof,cfg,type,ovf
// - extension flag zero, single footer byte
// - eof only in frame's last packet
// - payload type 0 measurement, 1 video
// - video packets many, one measurement packet
// - change flag for exactly one frame
// - overflow flag in all footers of the next accepted frame after loss
// - replies only between frames
// - values then one closing footer
module smf_framer
    import smf_pkg::*;
(
    input  wire logic        i_clock,     // 20 MHz
    input  wire logic        i_rst,       // sync, active high
    input  wire logic [7:0]  i_addr,      // register byte address
    input  wire logic [31:0] i_wdata,     // register write data
    input  wire logic        i_wr,        // write strobe
    input  wire logic        i_rd,        // read strobe
    output logic      [31:0] o_rdata,     // read data, cycle after i_rd
    output logic             o_irq,       // level interrupt
    input  wire logic        i_frame_start, // a new frame is ready
    input  wire smf_val_t    i_val,       // value with packet marks
    input  wire logic        i_val_valid, // value offered
    output logic             o_val_ready, // value taken when both high
    input  wire logic [7:0]  i_asc_byte,  // ascii reply byte
    input  wire logic        i_asc_valid, // reply byte offered
    output logic             o_asc_ready, // reply byte taken
    output logic      [7:0]  o_tx_byte,   // byte to the uart
    output logic             o_tx_valid,  // byte offered to the uart
    input  wire logic        i_tx_ready   // uart accepts the byte
);
    smf_state_t          st_q, st_d;      // framer state
    logic                en_q;            // framer enable
    logic [5:0]          wid_meas_q;      // programmed widths
    logic [5:0]          wid_vid_q;
    logic [5:0]          wid_meas_f_q;    // widths frozen for a frame
    logic [5:0]          wid_vid_f_q;
    logic [SMF_EV_N-1:0] mask_q;          // interrupt mask
    logic [SMF_EV_N-1:0] sts_q, sts_d;    // sticky events
    logic                cfg_pend_q;      // change waiting for a frame
    logic                ovf_pend_q;      // loss waiting for a frame
    logic                cfg_frame_q;     // flags of the current frame
    logic                ovf_frame_q;
    logic                in_frame_q;      // frame under way
    logic                in_frame_d;
    logic                meas_sent_q;     // measurement packet done
    logic [31:0]         data_q;          // value bits not yet sent
    logic [2:0]          left_q;          // bytes of the value left
    logic                five_q;          // value uses five bytes
    logic                pkt_last_q;      // marks of the value in flight
    logic                pkt_eof_q;
    logic                pkt_video_q;
    logic [7:0]          asc_q;           // held reply byte
    logic [7:0]          byte_d;          // next line byte
    logic                load;            // line byte loaded this cycle
    logic                out_free;        // output slot can take a byte
    logic                take;            // value accepted
    logic                dup;             // value of a second meas packet
    logic                frame_acc;       // frame accepted
    logic                frame_end;       // frame closed
    logic                lost;            // frame dropped
    logic                cfg_set;         // software changed the setup
    logic [5:0]          w_sel;           // width of the offered value
    logic [31:0]         enc_data;        // trimmed value
    logic [2:0]          enc_nb;          // its byte count
    smf_footer_t         foot;            // footer being built

    // software may write any width; keep it inside what the line carries
    function automatic logic [5:0] clamp_w(input logic [5:0] w);
        if (w < SMF_W_MIN) begin
            clamp_w = SMF_W_MIN;
        end else if (w > SMF_W_MAX) begin
            clamp_w = SMF_W_MAX;
        end else begin
            clamp_w = w;
        end
    endfunction

    // trims and sizes the offered value
    smf_val_enc #(
        .DW       (32)
    ) u_enc (
        .i_data   (i_val.data),
        .i_width  (w_sel),
        .o_data   (enc_data),
        .o_nbytes (enc_nb)
    );

    // handshake and frame level decisions
    always_comb begin
        out_free  = !o_tx_valid || i_tx_ready;
        take      = (st_q == SMF_ST_TAKE) && i_val_valid;
        w_sel     = i_val.video ? wid_vid_f_q : wid_meas_f_q;
        // a second measurement packet is dropped, not sent
        dup       = take && !i_val.video && meas_sent_q;
        frame_end = (st_q == SMF_ST_FOOT && out_free && pkt_eof_q)
                  || (dup && i_val.last && i_val.eof);
        frame_acc = i_frame_start && en_q && !in_frame_q;
        lost      = i_frame_start && en_q && in_frame_q;
        if (frame_acc) begin
            in_frame_d = 1'b1;
        end else if (frame_end) begin
            in_frame_d = 1'b0;
        end else begin
            in_frame_d = in_frame_q;
        end
        cfg_set = i_wr && ((i_addr == SMF_A_CTRL && i_wdata[SMF_CTRL_CFG_BIT])
                  || (i_addr == SMF_A_WIDTH
                      && (clamp_w(i_wdata[SMF_WID_MEAS_LSB +: 6]) != wid_meas_q
                       || clamp_w(i_wdata[SMF_WID_VID_LSB +: 6]) != wid_vid_q)));
    end

    // footer fields of the packet being closed
    always_comb begin
        foot.cont  = 1'b0;
        foot.ext   = 1'b0;
        foot.sep   = 1'b0;
        foot.eof   = pkt_eof_q;
        foot.cfg   = cfg_frame_q;
        foot.ptype = pkt_video_q ? SMF_PT_VIDEO : SMF_PT_MEAS;
        foot.ovf   = ovf_frame_q;
    end

    // sequencing: value bytes, then footer, replies only when idle
    always_comb begin
        st_d   = st_q;
        load   = 1'b0;
        byte_d = 8'h00;
        case (st_q)
            SMF_ST_IDLE: begin
                if (in_frame_q) begin
                    st_d = SMF_ST_TAKE;
                end else if (o_asc_ready && i_asc_valid) begin
                    st_d = SMF_ST_ASC;
                end
            end
            SMF_ST_ASC: begin
                if (out_free) begin
                    load   = 1'b1;
                    byte_d = asc_q;
                    st_d   = SMF_ST_IDLE;
                end
            end
            SMF_ST_TAKE: begin
                if (take && !dup) begin
                    st_d = SMF_ST_SEND;
                end else if (frame_end) begin
                    st_d = SMF_ST_IDLE;
                end
            end
            SMF_ST_SEND: begin
                if (out_free) begin
                    load   = 1'b1;
                    // continuation bit over the low group
                    byte_d = {left_q != 3'h1, data_q[SMF_GRP-1:0]};
                    if (left_q == 3'h1) begin
                        st_d = pkt_last_q ? SMF_ST_FOOT : SMF_ST_TAKE;
                    end
                end
            end
            SMF_ST_FOOT: begin
                if (out_free) begin
                    load   = 1'b1;
                    byte_d = foot;
                    st_d   = pkt_eof_q ? SMF_ST_IDLE : SMF_ST_TAKE;
                end
            end
            default: begin
                st_d = SMF_ST_IDLE;
            end
        endcase
    end

    // state and the two ready flags, both derived from the next state
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st_q        <= SMF_ST_IDLE;
            o_val_ready <= 1'b0;
            o_asc_ready <= 1'b0;
        end else begin
            st_q        <= st_d;
            o_val_ready <= (st_d == SMF_ST_TAKE);
            o_asc_ready <= (st_d == SMF_ST_IDLE) && !in_frame_d;
        end
    end

    // value in flight; shifting right pulls zeros into the top byte
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            data_q      <= 32'h0000_0000;
            left_q      <= 3'h0;
            five_q      <= 1'b0;
            pkt_last_q  <= 1'b0;
            pkt_eof_q   <= 1'b0;
            pkt_video_q <= 1'b0;
            asc_q       <= 8'h00;
        end else begin
            if (take && !dup) begin
                data_q      <= enc_data;
                left_q      <= enc_nb;
                five_q      <= (enc_nb == 3'h5);
                pkt_last_q  <= i_val.last;
                pkt_eof_q   <= i_val.eof;
                pkt_video_q <= i_val.video;
            end else if (st_q == SMF_ST_SEND && out_free) begin
                data_q <= data_q >> SMF_GRP;
                left_q <= left_q - 3'h1;
            end
            if (st_q == SMF_ST_IDLE && o_asc_ready && i_asc_valid
                && !in_frame_q) begin
                asc_q <= i_asc_byte;
            end
        end
    end

    // output slot towards the uart
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_tx_byte  <= 8'h00;
            o_tx_valid <= 1'b0;
        end else if (load) begin
            o_tx_byte  <= byte_d;
            o_tx_valid <= 1'b1;
        end else if (i_tx_ready) begin
            o_tx_valid <= 1'b0;
        end
    end

    // frame bookkeeping: flags and widths are frozen at frame start
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            in_frame_q   <= 1'b0;
            wid_meas_f_q <= SMF_RST_WMEAS;
            wid_vid_f_q  <= SMF_RST_WVID;
            cfg_frame_q  <= 1'b0;
            ovf_frame_q  <= 1'b0;
            meas_sent_q  <= 1'b0;
            cfg_pend_q   <= 1'b0;
            ovf_pend_q   <= 1'b0;
        end else begin
            in_frame_q <= in_frame_d;
            if (frame_acc) begin
                wid_meas_f_q <= wid_meas_q;
                wid_vid_f_q  <= wid_vid_q;
                cfg_frame_q  <= cfg_pend_q;
                ovf_frame_q  <= ovf_pend_q;
                meas_sent_q  <= 1'b0;
            end else if (st_q == SMF_ST_FOOT && out_free && !pkt_video_q) begin
                meas_sent_q <= 1'b1;
            end
            // a new change or loss in the hand-over cycle is kept
            cfg_pend_q <= cfg_set || (cfg_pend_q && !frame_acc);
            ovf_pend_q <= lost || (ovf_pend_q && !frame_acc);
        end
    end

    // software registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            en_q       <= SMF_RST_EN;
            wid_meas_q <= SMF_RST_WMEAS;
            wid_vid_q  <= SMF_RST_WVID;
            mask_q     <= SMF_RST_MASK;
        end else if (i_wr) begin
            case (i_addr)
                SMF_A_CTRL: begin
                    en_q <= i_wdata[SMF_CTRL_EN_BIT];
                end
                SMF_A_WIDTH: begin
                    wid_meas_q <= clamp_w(i_wdata[SMF_WID_MEAS_LSB +: 6]);
                    wid_vid_q  <= clamp_w(i_wdata[SMF_WID_VID_LSB +: 6]);
                end
                SMF_A_MASK: begin
                    mask_q <= i_wdata[SMF_EV_N-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // sticky events; an event in the clearing read's cycle survives
    always_comb begin
        sts_d = sts_q;
        if (i_rd && i_addr == SMF_A_STATUS) begin
            sts_d = '0;
        end
        sts_d[SMF_EV_FRAME] = sts_d[SMF_EV_FRAME] | frame_end;
        sts_d[SMF_EV_LOST]  = sts_d[SMF_EV_LOST] | lost;
        sts_d[SMF_EV_DUP]   = sts_d[SMF_EV_DUP] | dup;
    end

    // status, interrupt and read data
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sts_q   <= '0;
            o_irq   <= 1'b0;
            o_rdata <= 32'h0000_0000;
        end else begin
            sts_q   <= sts_d;
            o_irq   <= |(sts_d & mask_q);
            o_rdata <= 32'h0000_0000;
            if (i_rd) begin
                case (i_addr)
                    SMF_A_CTRL:   o_rdata <= {31'h0, en_q};
                    SMF_A_WIDTH:  o_rdata <= {18'h0, wid_vid_q, 2'h0,
                                              wid_meas_q};
                    SMF_A_STATUS: o_rdata <= {29'h0, sts_q};
                    SMF_A_MASK:   o_rdata <= {29'h0, mask_q};
                    SMF_A_STATE:  o_rdata <= {25'h0, in_frame_q, ovf_pend_q,
                                              cfg_pend_q, meas_sent_q, st_q};
                    default:      o_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // checks on the produced stream
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_byte_out;
        st_q == SMF_ST_SEND && out_free;
    endsequence
    sequence s_last_byte;
        s_byte_out ##0 left_q == 3'h1 && pkt_last_q;
    endsequence
    sequence s_foot_out;
        st_q == SMF_ST_FOOT && out_free;
    endsequence

    cont_bit_a: assert property (
        s_byte_out |=> o_tx_byte[7] == ($past(left_q) != 3'h1))
        else $error("continuation bit wrong");
    top_zero_a: assert property (
        s_byte_out ##0 left_q == 3'h1 && five_q |=> o_tx_byte[6:4] == 3'h0)
        else $error("fifth byte upper bits not zero");
    width_trim_a: assert property (
        take && !dup |=> (data_q & ~smf_mask($past(w_sel))) == 32'h0000_0000)
        else $error("unused value bits not cleared");
    width_hold_a: assert property (
        in_frame_q && $past(in_frame_q) |-> $stable(wid_meas_f_q)
            && $stable(wid_vid_f_q))
        else $error("width changed inside a frame");
    foot_fixed_a: assert property (
        s_foot_out |=> o_tx_byte[7] == 1'b0 && o_tx_byte[5] == 1'b0)
        else $error("footer fixed bits wrong");
    foot_ext_a: assert property (
        s_foot_out ##1 o_tx_valid |-> o_tx_byte[6] == 1'b0)
        else $error("footer extension set");
    foot_eof_a: assert property (
        s_foot_out |=> o_tx_byte[4] == $past(pkt_eof_q) && !in_frame_q
            == $past(pkt_eof_q) || $past(frame_acc))
        else $error("end-of-frame flag wrong");
    foot_type_a: assert property (
        s_foot_out |=> o_tx_byte[2:1] == {1'b0, $past(pkt_video_q)})
        else $error("payload type wrong");
    dup_drop_a: assert property (
        dup |=> st_q != SMF_ST_SEND)
        else $error("second measurement packet sent");
    foot_flags_a: assert property (
        s_foot_out |=> o_tx_byte[3] == $past(cfg_frame_q)
            && o_tx_byte[0] == $past(ovf_frame_q))
        else $error("change or overflow flag wrong");
    reply_gap_a: assert property (
        o_asc_ready |-> !in_frame_q && st_q == SMF_ST_IDLE)
        else $error("reply allowed inside a frame");
    // the footer itself must be loaded, not just a byte with bit 7 clear
    close_pkt_a: assert property (
        s_last_byte |=> st_q == SMF_ST_FOOT ##[0:1000] s_foot_out)
        else $error("packet not closed by a footer");
    loss_flag_a: assert property (
        lost |=> ovf_pend_q)
        else $error("frame loss not flagged");
    ovf_hand_a: assert property (
        ovf_pend_q && frame_acc |=> ovf_frame_q)
        else $error("overflow flag not handed to the frame");
endmodule

// file: dv/smf_host_rx.sv
`timescale 1ns/1ps
// host uart receiver model: takes line bytes and may stall the framer
module smf_host_rx (
    input  wire logic       i_clock,  // bench clock
    input  wire logic       i_rst,    // sync reset, active high
    input  wire logic       i_stall,  // 1: ready only every other cycle
    input  wire logic [7:0] i_byte,   // line byte from the framer
    input  wire logic       i_valid,  // line byte offered
    output logic            o_ready,  // uart accepts the byte
    output logic            o_take,   // byte taken at this edge
    output logic            o_footer  // taken byte closes a packet
);
    logic end_q; // last taken byte ended a value
    assign o_take = i_valid & o_ready;
    // a second clear top bit in a row is the footer
    assign o_footer = o_take & ~i_byte[7] & end_q;
    // stalling halves the rate, so the framer must hold its byte
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_ready <= 1'b0;
            end_q   <= 1'b0;
        end else begin
            o_ready <= i_stall ? ~o_ready : 1'b1;
            if (o_take) begin
                end_q <= ~i_byte[7] & ~end_q;
            end
        end
    end
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
// framer bench: register tasks, value packets and reply bytes
module testbench;
    import smf_pkg::*;
    logic        i_clock = 1'b0;  // 20 MHz
    logic        i_rst = 1'b1;    // sync reset
    logic [7:0]  i_addr = '0;     // register address
    logic [31:0] i_wdata = '0;    // register write data
    logic        i_wr = 1'b0;     // write strobe
    logic        i_rd = 1'b0;     // read strobe
    logic [31:0] o_rdata;         // read data
    logic        o_irq;           // interrupt
    logic        i_frame_start = 1'b0; // frame ready
    smf_val_t    i_val = '0;      // offered value
    logic        i_val_valid = 1'b0; // value offered
    logic        o_val_ready;     // value taken
    logic [7:0]  i_asc_byte = '0; // reply byte
    logic        i_asc_valid = 1'b0; // reply offered
    logic        o_asc_ready;     // reply taken
    logic [7:0]  o_tx_byte;       // line byte
    logic        o_tx_valid;      // line byte offered
    logic        i_tx_ready;      // uart ready
    logic        i_stall = 1'b1;  // uart stalls
    logic        take;            // uart took a byte
    logic        foot;            // that byte was a footer
    int          miscompares = 0; // mismatches
    int          check_count = 0; // comparisons
    int          cyc = 0;         // cycles run
    int          nfoot = 0;       // footers seen
    int          efoot = 0;       // footers expected
    logic [7:0]  got[$];          // bytes on the line
    logic [7:0]  exq[$];          // bytes expected
    logic [31:0] rv;              // read value

    smf_framer i_smf_framer (.i_clock(i_clock), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq), .i_frame_start(i_frame_start),
        .i_val(i_val), .i_val_valid(i_val_valid), .o_val_ready(o_val_ready),
        .i_asc_byte(i_asc_byte), .i_asc_valid(i_asc_valid),
        .o_asc_ready(o_asc_ready), .o_tx_byte(o_tx_byte),
        .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready));
    smf_host_rx i_smf_host_rx (.i_clock(i_clock), .i_rst(i_rst),
        .i_stall(i_stall), .i_byte(o_tx_byte), .i_valid(o_tx_valid),
        .o_ready(i_tx_ready), .o_take(take), .o_footer(foot));

    always #25 i_clock = ~i_clock;
    // collect line bytes; a hang ends the run
    always @(posedge i_clock) begin
        cyc++;
        if (take) got.push_back(o_tx_byte);
        if (foot) nfoot++;
        if (cyc == 3000) begin
            miscompares++;
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask
    // read data are taken one cycle after the strobe, once settled
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
        @(posedge i_clock);
    endtask
    task automatic fstart();
        i_frame_start <= 1'b1;
        @(posedge i_clock);
        i_frame_start <= 1'b0;
        @(posedge i_clock);
    endtask
    // one-value packet; expected bytes are built lsb group first
    task automatic pkt(input logic [31:0] d, input logic v, input logic e,
                       input int w, input logic [7:0] ft);
        int nb;
        i_val <= '{data: d, video: v, last: 1'b1, eof: e};
        i_val_valid <= 1'b1;
        do @(posedge i_clock); while (o_val_ready !== 1'b1);
        i_val_valid <= 1'b0;
        @(posedge i_clock);
        nb = w <= 14 ? 2 : w <= 21 ? 3 : w <= 28 ? 4 : 5;
        if (w < 32) d = d & ((32'h0000_0001 << w) - 32'h0000_0001);
        for (int k = 0; k < nb; k++) exq.push_back({k < nb-1, 7'(d >> 7*k)});
        exq.push_back(ft);
        efoot++;
        // a frame start before the frame closes would count as a loss
        if (e) do @(posedge i_clock); while (o_asc_ready !== 1'b1);
    endtask
    task automatic asc(input logic [7:0] b);
        i_asc_byte <= b;
        i_asc_valid <= 1'b1;
        do @(posedge i_clock); while (o_asc_ready !== 1'b1);
        i_asc_valid <= 1'b0;
        @(posedge i_clock);
        exq.push_back(b);
    endtask
    task automatic drain(input string name);
        repeat (40) @(posedge i_clock);
        chk(32'(got.size()), 32'(exq.size()));
        while (got.size() > 0 && exq.size() > 0)
            chk(got.pop_front(), exq.pop_front());
        chk(32'(nfoot), 32'(efoot));
        $display("test %s done", name);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rdc(SMF_A_WIDTH, 32'h0000_0E20);
        rdc(SMF_A_MASK, 32'h0000_0000);
        rdc(8'h40, 32'h0000_0000);
        rdc(SMF_A_STATUS, 32'h0000_0000);
        $display("test regs done");
        fstart();
        pkt(32'hF234_5678, 1'b0, 1'b1, 32, 8'h10);
        drain("meas32");
        i_stall <= 1'b0; // uart at full rate from here on
        fstart();
        chk(o_asc_ready, 1'b0);
        pkt(32'hFFFF_FFFF, 1'b1, 1'b0, 14, 8'h02);
        pkt(32'h0000_1234, 1'b1, 1'b0, 14, 8'h02);
        pkt(32'h8000_0001, 1'b0, 1'b1, 32, 8'h10);
        drain("video");
        wr(SMF_A_WIDTH, 32'h0000_0E05);
        rdc(SMF_A_WIDTH, 32'h0000_0E0E);
        fstart();
        pkt(32'h0003_FFFF, 1'b0, 1'b1, 14, 8'h18);
        fstart();
        pkt(32'h0000_2AAA, 1'b0, 1'b1, 14, 8'h10);
        drain("change");
        rdc(SMF_A_STATUS, 32'h0000_0001);
        wr(SMF_A_MASK, 32'h0000_0002);
        fstart();
        fstart();
        @(posedge i_clock);
        chk(o_irq, 1'b1);
        pkt(32'h0000_0055, 1'b0, 1'b1, 14, 8'h10);
        fstart();
        pkt(32'h0000_0066, 1'b0, 1'b1, 14, 8'h11);
        fstart();
        pkt(32'h0000_0077, 1'b0, 1'b1, 14, 8'h10);
        drain("loss");
        rdc(SMF_A_STATUS, 32'h0000_0003);
        @(posedge i_clock);
        chk(o_irq, 1'b0);
        asc(8'h3E);
        drain("reply");
        fstart();
        pkt(32'h0000_0123, 1'b0, 1'b0, 14, 8'h00);
        i_val <= '{data: 32'h0000_0456, video: 1'b0, last: 1'b1, eof: 1'b1};
        i_val_valid <= 1'b1;
        do @(posedge i_clock); while (o_val_ready !== 1'b1);
        i_val_valid <= 1'b0;
        drain("dup");
        rdc(SMF_A_STATUS, 32'h0000_0005);
        results();
    end
endmodule
